// File: hdl/svm_ctrl.sv
// Supply monitor control register, settle timer and flag logic
`timescale 1ns/1ps

// Overview of operation
// R1 - Control bits seven and six read zero
// R2 - Bit five shows reference has settled
// R3 - Bit four powers monitor up or down
// R4 - Level code 1111 selects external sense input
// R5 - Codes 0010 to 1110 select divider taps
// R6 - Settle after each enable before flags mean
// R7 - No flag event before reference is stable
// R8 - Settle delay fixed, not core-clock scaled
// R9 - Settle only when shared reference was off
// R10 - Spurious flag cleared by software after settling
// R11 - Clear loses to persisting undervolt condition
// R12 - Software programs level before enabling
// R13 - Software keeps interrupt off while settling
// R14 - Software polls stable flag before clearing
// R15 - Software enables interrupts last
// R16 - Software powers monitor only briefly
// R17 - Monitor runs in sleep, flag wakes
// R18 - Wake vectors only when globally enabled
// R19 - Reset clears register, monitor off; level code resets to 0101, not zero
// R20 - Comparator low sets undervolt flag
// R21 - Interrupt when flag and both enables
module svm_ctrl
    import svm_pkg::*;
#(
    parameter int SETTLE_CYCLES = SVM_SETTLE_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // AXI4-Lite write address
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog side
    input  wire logic        comparator_low,
    input  wire logic        shared_ref_on,
    output logic             monitor_power_enable,
    output logic [3:0]       trip_level_select,
    output logic             sense_external,
    // Core side
    output logic             undervolt_irq,
    output logic             wake_request,
    output logic             wake_to_vector
);

    // Control and status state
    svm_ctrl_t  ctrl, next_ctrl;            // Enable and level
    svm_state_t state, next_state;          // Settling machine
    logic [15:0] settle_cnt, next_settle_cnt; // Settle countdown
    logic       flag, next_flag;            // Undervolt flag
    logic       irq_en, next_irq_en;        // Flag interrupt enable
    logic       global_irq_enable, next_gie;              // Global interrupt enable
    logic       asleep, next_asleep;        // Core sleeping

    // Comparator synchroniser
    logic       cmp_s1, cmp_s2, cmp_s3;     // Three-stage chain
    logic       cmp_low, next_cmp_low;      // Filtered comparator
    logic       ref_s1, ref_s2, ref_s3;     // Shared reference chain
    logic       ref_on, next_ref_on;        // Filtered reference state

    // Bus state
    logic        aw_held, next_aw_held;     // Write address captured
    logic        w_held, next_w_held;       // Write data captured
    logic [3:0]  aw_addr, next_aw_addr;     // Captured address
    logic [31:0] w_data, next_w_data;       // Captured data
    logic        w_strb0, next_w_strb0;     // Low byte lane
    logic        bvalid, next_bvalid;       // Write response pending
    logic [1:0]  bresp, next_bresp;         // Write response code
    logic        rvalid, next_rvalid;       // Read data pending
    logic [31:0] rdata, next_rdata;         // Read data
    logic [1:0]  rresp, next_rresp;         // Read response code
    logic        irq_q, next_irq_q;         // Registered interrupt
    logic        wake_q, next_wake_q;       // Registered wake pulse
    logic        vec_q, next_vec_q;         // Registered vector choice

    // Decoded access strobes and status conditions
    logic        do_write;
    logic        do_read;
    logic        stable;
    logic        event_valid;

    // Input synchronisers, first stage read only by the second
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cmp_s1 <= 1'b0;
            cmp_s2 <= 1'b0;
            cmp_s3 <= 1'b0;
            ref_s1 <= 1'b0;
            ref_s2 <= 1'b0;
            ref_s3 <= 1'b0;
        end else begin
            cmp_s1 <= comparator_low;
            cmp_s2 <= cmp_s1;
            cmp_s3 <= cmp_s2;
            ref_s1 <= shared_ref_on;
            ref_s2 <= ref_s1;
            ref_s3 <= ref_s2;
        end
    end

    // Accept a change once second and third stages agree
    always_comb begin
        next_cmp_low = (cmp_s2 == cmp_s3) ? cmp_s3 : cmp_low;
        next_ref_on  = (ref_s2 == ref_s3) ? ref_s3 : ref_on;
    end

    // Derived conditions
    assign stable      = (state == SVM_STABLE);
    assign do_write    = aw_held && w_held && !bvalid;
    assign do_read     = s_axi_arvalid && !rvalid;
    // Events count only once settled and powered (see R7) (see R20)
    assign event_valid = stable && ctrl.power_enable && cmp_low;

    // Bus channel handshakes and register writes
    always_comb begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb0 = w_strb0;
        next_bvalid  = bvalid;
        next_bresp   = bresp;
        next_rvalid  = rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        next_ctrl    = ctrl;
        next_irq_en  = irq_en;
        next_gie     = global_irq_enable;
        next_asleep  = asleep;
        next_flag    = flag;
        // Address and data taken in either order
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held  = 1'b1;
            next_w_data  = s_axi_wdata;
            next_w_strb0 = s_axi_wstrb[0];
        end
        // Write commits once both halves are held
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = SVM_RESP_OK;
            case (aw_addr)
                SVM_CTRL_ADDR: begin
                    // Only enable and level are writable (see R3) (see R4)
                    if (w_strb0) begin
                        next_ctrl.power_enable = w_data[SVM_EN_BIT];
                        next_ctrl.trip_level   = w_data[SVM_LVL_MSB:0];
                    end
                end
                SVM_STATUS_ADDR: begin
                    if (w_strb0) begin
                        // Writing zero clears the flag (see R10)
                        if (!w_data[SVM_FLAG_BIT]) begin
                            next_flag = 1'b0;
                        end
                        next_irq_en = w_data[SVM_IE_BIT];
                        next_gie    = w_data[SVM_GIE_BIT];
                    end
                end
                SVM_SLEEP_ADDR: begin
                    if (w_strb0) begin
                        next_asleep = w_data[0];
                    end
                end
                default: begin
                    next_bresp = SVM_RESP_ERR;
                end
            endcase
        end else if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // Persisting condition sets again over a clear (see R11)
        if (event_valid) begin
            next_flag = 1'b1;
        end
        // Wake on a flag event ends sleep (see R17)
        if (event_valid && asleep) begin
            next_asleep = 1'b0;
        end
        // Read channel
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rresp  = SVM_RESP_OK;
            next_rdata  = 32'h0000_0000;
            case (s_axi_araddr)
                SVM_CTRL_ADDR: begin
                    // Bits seven and six stay zero (see R1) (see R2)
                    next_rdata[SVM_STABLE_BIT] = stable && ctrl.power_enable;
                    next_rdata[SVM_EN_BIT]     = ctrl.power_enable;
                    next_rdata[SVM_LVL_MSB:0]  = ctrl.trip_level;
                end
                SVM_STATUS_ADDR: begin
                    next_rdata[SVM_FLAG_BIT] = flag;
                    next_rdata[SVM_IE_BIT]   = irq_en;
                    next_rdata[SVM_GIE_BIT]  = global_irq_enable;
                end
                SVM_SLEEP_ADDR: begin
                    next_rdata[0] = asleep;
                end
                default: begin
                    next_rresp = SVM_RESP_ERR;
                end
            endcase
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // Settling machine, counted in fixed-time cycles (see R8)
    always_comb begin
        next_state      = state;
        next_settle_cnt = settle_cnt;
        case (state)
            SVM_OFF: begin
                if (ctrl.power_enable) begin
                    // Shared reference already up needs no settle (see R9)
                    if (ref_on) begin
                        next_state = SVM_STABLE;
                    end else begin
                        next_state      = SVM_SETTLING;
                        next_settle_cnt = 16'(SETTLE_CYCLES - 1);
                    end
                end
            end
            SVM_SETTLING: begin
                // Each enable with the shared reference off restarts settling (see R6)
                if (!ctrl.power_enable) begin
                    next_state = SVM_OFF;
                end else if (settle_cnt == 16'h0000) begin
                    next_state = SVM_STABLE;
                end else begin
                    next_settle_cnt = settle_cnt - 16'h0001;
                end
            end
            SVM_STABLE: begin
                if (!ctrl.power_enable) begin
                    next_state = SVM_OFF;
                end
            end
            default: begin
                next_state = SVM_OFF;
            end
        endcase
    end

    // Interrupt and wake outputs
    always_comb begin
        // Flag and both enables raise the request (see R21)
        next_irq_q  = flag && irq_en && global_irq_enable;
        next_wake_q = event_valid && asleep;
        // Vector only when globally enabled (see R18)
        next_vec_q  = event_valid && asleep && global_irq_enable;
    end

    // Register all state but the synchronisers and ext_q; reset turns the monitor off (see R19)
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl.power_enable <= 1'b0;
            ctrl.trip_level   <= SVM_LVL_RST;
            state      <= SVM_OFF;
            settle_cnt <= 16'h0000;
            flag       <= 1'b0;
            irq_en     <= 1'b0;
            global_irq_enable        <= 1'b0;
            asleep     <= 1'b0;
            cmp_low    <= 1'b0;
            ref_on     <= 1'b0;
            aw_held    <= 1'b0;
            w_held     <= 1'b0;
            aw_addr    <= 4'h0;
            w_data     <= 32'h0000_0000;
            w_strb0    <= 1'b0;
            bvalid     <= 1'b0;
            bresp      <= SVM_RESP_OK;
            rvalid     <= 1'b0;
            rdata      <= 32'h0000_0000;
            rresp      <= SVM_RESP_OK;
            irq_q      <= 1'b0;
            wake_q     <= 1'b0;
            vec_q      <= 1'b0;
        end else begin
            ctrl       <= next_ctrl;
            state      <= next_state;
            settle_cnt <= next_settle_cnt;
            flag       <= next_flag;
            irq_en     <= next_irq_en;
            global_irq_enable        <= next_gie;
            asleep     <= next_asleep;
            cmp_low    <= next_cmp_low;
            ref_on     <= next_ref_on;
            aw_held    <= next_aw_held;
            w_held     <= next_w_held;
            aw_addr    <= next_aw_addr;
            w_data     <= next_w_data;
            w_strb0    <= next_w_strb0;
            bvalid     <= next_bvalid;
            bresp      <= next_bresp;
            rvalid     <= next_rvalid;
            rdata      <= next_rdata;
            rresp      <= next_rresp;
            irq_q      <= next_irq_q;
            wake_q     <= next_wake_q;
            vec_q      <= next_vec_q;
        end
    end

    // Outputs straight from flip-flops
    assign s_axi_awready        = !aw_held;
    assign s_axi_wready         = !w_held;
    assign s_axi_bvalid         = bvalid;
    assign s_axi_bresp          = bresp;
    assign s_axi_arready        = !rvalid;
    assign s_axi_rvalid         = rvalid;
    assign s_axi_rdata          = rdata;
    assign s_axi_rresp          = rresp;
    // Monitor powers per enable bit (see R3)
    assign monitor_power_enable = ctrl.power_enable;
    // Tap code passes through, codes 2 to 14 are taps (see R5)
    assign trip_level_select    = ctrl.trip_level;
    assign undervolt_irq        = irq_q;
    assign wake_request         = wake_q;
    assign wake_to_vector       = vec_q;

    // External sense mode decode (see R4)
    logic ext_q;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ext_q <= 1'b0;
        end else begin
            ext_q <= (next_ctrl.trip_level == SVM_LVL_EXT);
        end
    end
    assign sense_external = ext_q;

endmodule

// File: hdl/svm_pkg.sv
// Package of constants and types for the supply monitor control block
package svm_pkg;

    // Register byte addresses
    localparam logic [3:0] SVM_CTRL_ADDR   = 4'h0;  // supply_monitor_control
    localparam logic [3:0] SVM_STATUS_ADDR = 4'h4;  // undervolt flag / enables
    localparam logic [3:0] SVM_SLEEP_ADDR  = 4'h8;  // sleep request

    // Control register field positions
    localparam int SVM_STABLE_BIT = 5;
    localparam int SVM_EN_BIT     = 4;
    localparam int SVM_LVL_MSB    = 3;

    // Status register field positions
    localparam int SVM_FLAG_BIT   = 0;
    localparam int SVM_IE_BIT     = 1;
    localparam int SVM_GIE_BIT    = 2;

    // Level codes: reset value, external sense and lowest tap
    localparam logic [3:0] SVM_LVL_RST  = 4'h5;
    localparam logic [3:0] SVM_LVL_EXT  = 4'hF;
    localparam logic [3:0] SVM_LVL_MIN  = 4'h2;

    // Settling time in nanoseconds, and its cycle count at 100 MHz
    localparam int SVM_CLK_NS       = 10;
    localparam int SVM_SETTLE_NS    = 20000;
    localparam int SVM_SETTLE_CYC   =
        (SVM_SETTLE_NS + SVM_CLK_NS - 1) / SVM_CLK_NS;

    // AXI response codes
    localparam logic [1:0] SVM_RESP_OK  = 2'h0;
    localparam logic [1:0] SVM_RESP_ERR = 2'h2;

    // Settling state machine
    typedef enum logic [1:0] {
        SVM_OFF,
        SVM_SETTLING,
        SVM_STABLE
    } svm_state_t;

    // Control fields carried together
    typedef struct packed {
        logic       power_enable;
        logic [3:0] trip_level;
    } svm_ctrl_t;

endpackage

// File: testbench/svm_ctrl_monitor.sv
// Checker for the supply monitor control block
`timescale 1ns/1ps
module svm_ctrl_monitor
    import svm_pkg::*;
#(
    parameter int SETTLE_CYCLES = SVM_SETTLE_CYC
) (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // Register bus
    input wire logic [3:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [3:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    // Analog and core side
    input wire logic        shared_ref_on,
    input wire logic        monitor_power_enable,
    input wire logic [3:0]  trip_level_select,
    input wire logic        sense_external,
    input wire logic        wake_request,
    input wire logic        wake_to_vector
);
    logic       wr_ctrl;   // Write aimed at control
    logic [7:0] wr_byte;   // Last accepted data byte
    logic       wr_keep;   // Byte lane zero enabled
    logic       rd_ctrl;   // Read aimed at control
    logic       ref_at_en; // Reference state when enabled
    int         en_cnt;    // Cycles since power enable

    // Capture request fields as the bus takes them
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wr_ctrl   <= 1'b0;
            wr_byte   <= 8'h00;
            wr_keep   <= 1'b0;
            rd_ctrl   <= 1'b0;
            ref_at_en <= 1'b0;
            en_cnt    <= 0;
        end else begin
            if (s_axi_awvalid && s_axi_awready)
                wr_ctrl <= (s_axi_awaddr == SVM_CTRL_ADDR);
            if (s_axi_wvalid && s_axi_wready) begin
                wr_byte <= s_axi_wdata[7:0];
                wr_keep <= s_axi_wstrb[0];
            end
            if (s_axi_arvalid && s_axi_arready)
                rd_ctrl <= (s_axi_araddr == SVM_CTRL_ADDR);
            // Saturating count of powered cycles
            if (!monitor_power_enable) begin
                en_cnt    <= 0;
                ref_at_en <= shared_ref_on;
            end else if (en_cnt < SETTLE_CYCLES)
                en_cnt <= en_cnt + 1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_top_bits_zero: assert property (
        s_axi_rvalid && rd_ctrl |-> s_axi_rdata[31:6] == '0)
        else $error("control read shows upper bits set");
    a_stable_needs_en: assert property (
        s_axi_rvalid && rd_ctrl && s_axi_rdata[5] |-> s_axi_rdata[4])
        else $error("stable flag while powered down");
    a_settle_time: assert property (
        s_axi_rvalid && rd_ctrl && s_axi_rdata[5] && !ref_at_en
        |-> en_cnt >= SETTLE_CYCLES)
        else $error("stable flag before settling time");
    a_ctrl_write: assert property (
        $rose(s_axi_bvalid) && wr_ctrl && wr_keep
        |-> monitor_power_enable == wr_byte[4]
            && trip_level_select == wr_byte[3:0])
        else $error("control outputs differ from write");
    a_ext_sense: assert property (
        sense_external == (trip_level_select == SVM_LVL_EXT))
        else $error("external sense select wrong");
    a_reset_off: assert property (
        $past(rst) |-> !monitor_power_enable
            && trip_level_select == SVM_LVL_RST)
        else $error("reset did not restore control");
    a_wake_pulse: assert property (
        wake_request |=> !wake_request)
        else $error("wake request longer than one cycle");
    a_wake_gated: assert property (
        wake_to_vector |-> wake_request)
        else $error("vector wake without wake request");

    // Main scenarios reached
    c_stable: cover property (s_axi_rvalid && rd_ctrl && s_axi_rdata[5]);
    c_vector: cover property (wake_to_vector);
    c_ctrl_wr: cover property ($rose(s_axi_bvalid) && wr_ctrl);
endmodule

bind svm_ctrl svm_ctrl_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES))
    i_mon (.*);

// File: testbench/tb_svm_ctrl.sv
// Self-checking testbench for the supply monitor control block
`timescale 1ns/1ps
module tb_svm_ctrl
    import svm_pkg::*;
;
    localparam int SET_P = 16;  // Shortened settle count
    logic sys_clk = 0, rst = 1;
    logic [3:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic awvalid = 0, wvalid = 0, bready = 0;
    logic arvalid = 0, rready = 0, awready, wready, arready;
    logic bvalid, rvalid, comp_low = 0, ref_on = 0;
    logic [1:0] bresp, rresp, lresp;
    logic [31:0] ldata;   // Last read data
    logic pwr, sense, irq, wake, vec;
    logic [3:0] lvl;
    int bad_count = 0, num_checks = 0, wakes = 0, vecs = 0, n;
    time t0;

    always #5 sys_clk = ~sys_clk;

    svm_ctrl #(.SETTLE_CYCLES(SET_P)) i_dut (
        .sys_clk(sys_clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .comparator_low(comp_low),
        .shared_ref_on(ref_on), .monitor_power_enable(pwr),
        .trip_level_select(lvl), .sense_external(sense),
        .undervolt_irq(irq), .wake_request(wake),
        .wake_to_vector(vec));

    // Count one-cycle wake pulses
    always @(posedge sys_clk) begin
        if (wake === 1'b1) wakes++;
        if (vec === 1'b1) vecs++;
    end

    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    // Write one word, holding each channel until taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        lresp = bresp;
        // Ready stays high; the next call drives it again
        if (n >= 100) begin
            chk(0, 1, "write timeout");
            end_sim();
        end
    endtask

    // Read one word, holding the address until taken
    task automatic rd(input logic [3:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        ldata = rdata;
        lresp = rresp;
        if (n >= 100) begin
            chk(0, 1, "read timeout");
            end_sim();
        end
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge sys_clk);
    endtask

    initial begin
        idle(8);
        rst <= 1'b0;
        // Reset state of control and status registers
        rd(SVM_CTRL_ADDR);
        chk(ldata, 32'h05, "ctrl reset value");
        rd(SVM_STATUS_ADDR);
        chk(ldata, 32'h00, "status reset value");
        $display("test reset done");
        // Every divider tap code, then external mode
        for (int l = 2; l < 15; l++) begin
            wr(SVM_CTRL_ADDR, l);
            chk({lvl, sense}, {l[3:0], 1'b0}, "tap select");
        end
        wr(SVM_CTRL_ADDR, 32'hEF);
        rd(SVM_CTRL_ADDR);
        chk(ldata, 32'h0F, "read-only bits");
        chk(sense, 1'b1, "external sense");
        $display("test levels done");
        // Level first, then enable with comparator already low
        wr(SVM_CTRL_ADDR, 32'h07);
        comp_low <= 1'b1;
        wr(SVM_CTRL_ADDR, 32'h17);
        t0 = $time;
        chk(pwr, 1'b1, "power enable");
        idle(6);
        rd(SVM_STATUS_ADDR);
        chk(ldata, 32'h00, "flag before stable");
        for (int k = 0; k < 50 && ldata[5] !== 1'b1; k++)
            rd(SVM_CTRL_ADDR);
        chk(ldata, 32'h37, "stable flag");
        chk(($time - t0) / 10 >= SET_P, 1, "settle too short");
        idle(6);
        rd(SVM_STATUS_ADDR);
        chk(ldata, 32'h01, "flag set");
        wr(SVM_STATUS_ADDR, 32'h00);
        rd(SVM_STATUS_ADDR);
        chk(ldata, 32'h01, "flag held while low");
        comp_low <= 1'b0;
        idle(5);
        wr(SVM_STATUS_ADDR, 32'h00);
        rd(SVM_STATUS_ADDR);
        chk(ldata, 32'h00, "flag cleared");
        $display("test settle done");
        // Interrupt raised with both enables, masked by global enable
        wr(SVM_STATUS_ADDR, 32'h06);
        comp_low <= 1'b1;
        idle(8);
        chk(irq, 1'b1, "irq raised");
        wr(SVM_STATUS_ADDR, 32'h03);
        idle(2);
        chk(irq, 1'b0, "irq masked");
        comp_low <= 1'b0;
        idle(5);
        // Sleep wake with and without global enable
        wr(SVM_STATUS_ADDR, 32'h04);
        wr(SVM_SLEEP_ADDR, 32'h01);
        comp_low <= 1'b1;
        idle(8);
        chk({wakes[7:0], vecs[7:0]}, 16'h0101, "vector wake");
        rd(SVM_SLEEP_ADDR);
        chk(ldata, 32'h00, "asleep cleared");
        comp_low <= 1'b0;
        idle(5);
        wr(SVM_STATUS_ADDR, 32'h00);
        wr(SVM_SLEEP_ADDR, 32'h01);
        comp_low <= 1'b1;
        idle(8);
        chk({wakes[7:0], vecs[7:0]}, 16'h0201, "wake in place");
        comp_low <= 1'b0;
        $display("test sleep done");
        // Shared reference up, disable, then enable again
        ref_on <= 1'b1;
        wr(SVM_CTRL_ADDR, 32'h07);
        rd(SVM_CTRL_ADDR);
        chk({pwr, ldata[30:0]}, {1'b0, 31'h07}, "disabled");
        wr(SVM_CTRL_ADDR, 32'h17);
        idle(2);
        rd(SVM_CTRL_ADDR);
        chk(ldata, 32'h37, "quick stable");
        // Unmapped place answers with an error
        rd(4'hC);
        chk({lresp, ldata[29:0]}, {SVM_RESP_ERR, 30'h0}, "unmapped read");
        wr(4'hC, 32'h11);
        chk(lresp, SVM_RESP_ERR, "unmapped write");
        // Reset in mid-run
        rst <= 1'b1;
        idle(2);
        rst <= 1'b0;
        rd(SVM_CTRL_ADDR);
        chk({pwr, ldata[30:0]}, {1'b0, 31'h05}, "late reset");
        $display("test misc done");
        end_sim();
    end
endmodule
